// ===== rtl/smd_unit.sv
// arithmetic execution unit: multiply, divide, saturating add and subtract
`timescale 1ns/1ps
module smd_unit
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   // request
   input  wire logic              i_enable,
   input  wire smd_pkg::smd_op_type i_op,
   input  wire logic [15:0]       i_a_lo,
   input  wire logic [15:0]       i_a_hi,
   input  wire logic [15:0]       i_b_lo,
   input  wire logic [15:0]       i_b_hi,
   input  wire logic              i_dest_index,
   // error flag control
   input  wire logic              i_error_clear,
   // results
   output logic [15:0]            o_dest_lo,
   output logic [15:0]            o_dest_hi,
   output logic                   o_write_lo,
   output logic                   o_write_hi,
   output logic                   o_result_valid,
   output logic                   o_instruction_error_flag
);
   import smd_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // saturating 32-bit add or subtract; flag raised on clamp
   // the exact 33-bit result avoids negating the most negative subtrahend
   function automatic logic [32:0] sat32(input logic [31:0] x, input logic [31:0] y,
                                         input logic sub);
      logic [32:0] r;
      r = sub ? 33'({x[31], x} - {y[31], y}) : 33'({x[31], x} + {y[31], y});
      if (!r[32] && r[31])
         sat32 = {1'b1, DWORD_MAX};
      else if (r[32] && !r[31])
         sat32 = {1'b1, DWORD_MIN};
      else
         sat32 = {1'b0, r[31:0]};
   endfunction : sat32

   // one operation taking effect at this edge
   function automatic logic fires(input logic en, input smd_op_type cur,
                                  input smd_op_type want);
      fires = en && (cur == want);
   endfunction : fires

   // ------------------------------------------------------------
   // combinational datapath
   // ------------------------------------------------------------
   logic [15:0] quo;
   logic [15:0] rem;
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [31:0] prod;
   logic [32:0] dadd;
   logic [32:0] dsub;
   logic [16:0] wsub;
   logic        div_zero;
   logic [15:0] lo_nxt;
   logic [15:0] hi_nxt;
   logic        wlo_nxt;
   logic        whi_nxt;
   logic        out_nxt;

   smd_divider u_div
   (
      .i_dividend  (i_a_lo),
      .i_divisor   (i_b_lo),
      .o_quotient  (quo),
      .o_remainder (rem)
   );

   assign op_a     = {i_a_hi, i_a_lo};
   assign op_b     = {i_b_hi, i_b_lo};
   assign prod     = 32'($signed(i_a_lo) * $signed(i_b_lo));
   assign dadd     = sat32(op_a, op_b, 1'b0);
   assign dsub     = sat32(op_a, op_b, 1'b1);
   assign wsub     = 17'({i_a_lo[15], i_a_lo} - {i_b_lo[15], i_b_lo});
   assign div_zero = (i_b_lo == WORD_ZERO);

   always_comb
   begin
      lo_nxt  = o_dest_lo;
      hi_nxt  = o_dest_hi;
      wlo_nxt = 1'b0;
      whi_nxt = 1'b0;
      out_nxt = 1'b0;
      if (i_enable)
      begin
         case (i_op)
            SMD_OP_MUL:
            begin
               lo_nxt  = prod[15:0];
               hi_nxt  = prod[31:16];
               wlo_nxt = 1'b1;
               whi_nxt = 1'b1;
               out_nxt = 1'b1;
            end
            SMD_OP_DIV:
            begin
               if (!div_zero)
               begin
                  lo_nxt  = quo;
                  hi_nxt  = rem;
                  wlo_nxt = 1'b1;
                  whi_nxt = !i_dest_index;
                  out_nxt = 1'b1;
               end
            end
            SMD_OP_DADD:
            begin
               lo_nxt  = dadd[15:0];
               hi_nxt  = dadd[31:16];
               wlo_nxt = 1'b1;
               whi_nxt = 1'b1;
               out_nxt = dadd[32];
            end
            SMD_OP_DSUB:
            begin
               lo_nxt  = dsub[15:0];
               hi_nxt  = dsub[31:16];
               wlo_nxt = 1'b1;
               whi_nxt = 1'b1;
               out_nxt = dsub[32];
            end
            SMD_OP_SUB:
            begin
               wlo_nxt = 1'b1;
               if (wsub[16] && !wsub[15])
               begin
                  lo_nxt  = WORD_MIN;
                  out_nxt = 1'b1;
               end
               else if (!wsub[16] && wsub[15])
               begin
                  lo_nxt  = WORD_MAX;
                  out_nxt = 1'b1;
               end
               else
                  lo_nxt  = wsub[15:0];
            end
            default:
            begin
               out_nxt = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // result registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_dest_lo      <= 16'h0000;
         o_dest_hi      <= 16'h0000;
         o_write_lo     <= 1'b0;
         o_write_hi     <= 1'b0;
         o_result_valid <= 1'b0;
      end
      else
      begin
         o_dest_lo      <= lo_nxt;
         o_dest_hi      <= hi_nxt;
         o_write_lo     <= wlo_nxt;
         o_write_hi     <= whi_nxt;
         o_result_valid <= out_nxt;
      end
   end

   // ------------------------------------------------------------
   // instruction error flag
   // ------------------------------------------------------------
   logic err_set;
   assign err_set = i_enable && (i_op == SMD_OP_DIV) && div_zero;

   // set wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_instruction_error_flag <= 1'b0;
      else if (err_set)
         o_instruction_error_flag <= 1'b1;
      else if (i_error_clear)
         o_instruction_error_flag <= 1'b0;
   end

   // ------------------------------------------------------------
   // assertion helpers
   // ------------------------------------------------------------
   // plain wrapped results, independent of the clamping path
   logic [31:0] add_wrap;
   logic [31:0] sub_wrap;
   assign add_wrap = 32'(op_a + op_b);
   assign sub_wrap = 32'(op_a - op_b);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   idle_quiet_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !i_enable |=> !o_result_valid && !o_write_lo && $stable(o_dest_lo))
      else $error("disabled unit changed outputs");

   mul_product_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_enable && i_op == SMD_OP_MUL) |=>
      ({o_dest_hi, o_dest_lo} == $past(prod)) && o_result_valid)
      else $error("multiply result wrong");

   div_identity_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_enable && i_op == SMD_OP_DIV && !div_zero && !(i_a_lo == WORD_MIN && i_b_lo == WORD_M1))
      |=> 16'($past(i_b_lo) * o_dest_lo + o_dest_hi) == $past(i_a_lo))
      else $error("divide identity broken");

   div_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      err_set |=> o_instruction_error_flag && !o_result_valid && !o_write_lo && !o_write_hi)
      else $error("zero divisor handled wrongly");

   flag_sticky_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (o_instruction_error_flag && !i_error_clear) |=> o_instruction_error_flag)
      else $error("error flag cleared by itself");

   index_dest_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_enable && i_op == SMD_OP_DIV && !div_zero && i_dest_index) |=> o_write_lo && !o_write_hi)
      else $error("remainder written to index");

   min_by_m1_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_enable && i_op == SMD_OP_DIV && i_a_lo == WORD_MIN && i_b_lo == WORD_M1 && !i_dest_index)
      |=> o_dest_lo == WORD_MIN && o_dest_hi == WORD_ZERO && !$rose(o_instruction_error_flag))
      else $error("min by minus one wrong");

   dadd_sat_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_enable && i_op == SMD_OP_DADD && !op_a[31] && !op_b[31] && add_wrap[31])
      |=> {o_dest_hi, o_dest_lo} == DWORD_MAX && o_result_valid)
      else $error("add overflow not clamped");

   dsub_flag_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_enable && i_op == SMD_OP_DSUB && op_a[31] && !op_b[31] && !sub_wrap[31])
      |=> o_result_valid && ({o_dest_hi, o_dest_lo} == DWORD_MIN))
      else $error("subtract underflow flag wrong");

   idle_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !i_enable |=> !o_write_hi && $stable(o_dest_hi))
      else $error("disabled unit wrote high word");

   mul_strobe_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      fires(i_enable, i_op, SMD_OP_MUL) |=> o_write_lo && o_write_hi && o_result_valid)
      else $error("multiply strobes missing");

   div_valid_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DIV) && !div_zero) |=> o_result_valid && o_write_lo)
      else $error("divide output missing");

   div_place_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DIV) && !div_zero && !i_dest_index)
      |=> o_write_lo && o_write_hi)
      else $error("divide words not both written");

   rem_sign_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DIV) && !div_zero)
      |=> (o_dest_hi == WORD_ZERO) || (o_dest_hi[15] == $past(i_a_lo[15])))
      else $error("remainder sign wrong");

   quo_sign_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DIV) && !div_zero &&
       !(i_a_lo == WORD_MIN && i_b_lo == WORD_M1))
      |=> (o_dest_lo == WORD_ZERO) ||
          (o_dest_lo[15] == ($past(i_a_lo[15]) ^ $past(i_b_lo[15]))))
      else $error("quotient sign wrong");

   flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (o_instruction_error_flag && i_error_clear && !err_set)
      |=> !o_instruction_error_flag)
      else $error("error flag not cleared");

   flag_cause_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (!o_instruction_error_flag && !err_set) |=> !o_instruction_error_flag)
      else $error("error flag set without cause");

   dadd_sum_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DADD) &&
       (op_a[31] != op_b[31] || add_wrap[31] == op_a[31]))
      |=> {o_dest_hi, o_dest_lo} == $past(add_wrap) && !o_result_valid)
      else $error("double add result wrong");

   dadd_under_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DADD) && op_a[31] && op_b[31] && !add_wrap[31])
      |=> {o_dest_hi, o_dest_lo} == DWORD_MIN && o_result_valid)
      else $error("add underflow not clamped");

   dsub_diff_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DSUB) &&
       (op_a[31] == op_b[31] || sub_wrap[31] == op_a[31]))
      |=> {o_dest_hi, o_dest_lo} == $past(sub_wrap) && !o_result_valid)
      else $error("double subtract result wrong");

   dsub_over_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_DSUB) && !op_a[31] && op_b[31] && sub_wrap[31])
      |=> {o_dest_hi, o_dest_lo} == DWORD_MAX && o_result_valid)
      else $error("subtract overflow not clamped");

   sub_clamp_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_SUB) && (wsub[16] != wsub[15]))
      |=> o_result_valid && o_dest_lo == ($past(i_a_lo[15]) ? WORD_MIN : WORD_MAX))
      else $error("word subtract clamp wrong");

   sub_plain_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (fires(i_enable, i_op, SMD_OP_SUB) && (wsub[16] == wsub[15]))
      |=> !o_result_valid && o_write_lo && !o_write_hi &&
          o_dest_lo == $past(16'(i_a_lo - i_b_lo)))
      else $error("word subtract result wrong");
endmodule : smd_unit

// ===== rtl/smd_pkg.sv
// package: operation codes, widths and limit constants for the arithmetic unit
package smd_pkg;
   localparam int W_WORD = 16;
   localparam int W_DWORD = 32;
   localparam logic [15:0] WORD_MIN = 16'h8000;
   localparam logic [15:0] WORD_MAX = 16'h7FFF;
   localparam logic [15:0] WORD_M1 = 16'hFFFF;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [31:0] DWORD_MIN = 32'h80000000;
   localparam logic [31:0] DWORD_MAX = 32'h7FFFFFFF;
   typedef enum logic [2:0]
   {
      SMD_OP_MUL,
      SMD_OP_DIV,
      SMD_OP_DADD,
      SMD_OP_DSUB,
      SMD_OP_SUB
   } smd_op_type;
endpackage : smd_pkg

// ===== rtl/smd_divider.sv
// signed 16-bit combinational divider, truncating toward zero
`timescale 1ns/1ps
module smd_divider
(
   // operands
   input  wire logic [15:0] i_dividend,
   input  wire logic [15:0] i_divisor,
   // results
   output logic      [15:0] o_quotient,
   output logic      [15:0] o_remainder
);
   import smd_pkg::*;
   logic [15:0] mag_a;
   logic [15:0] mag_b;
   logic [15:0] q_mag;
   logic [15:0] r_mag;
   // magnitudes are unsigned so the most negative value survives negation
   always_comb
   begin
      mag_a = i_dividend[15] ? 16'(~i_dividend + 16'h0001) : i_dividend;
      mag_b = i_divisor[15] ? 16'(~i_divisor + 16'h0001) : i_divisor;
      q_mag = (mag_b == WORD_ZERO) ? WORD_ZERO : 16'(mag_a / mag_b);
      r_mag = (mag_b == WORD_ZERO) ? WORD_ZERO : 16'(mag_a % mag_b);
      if ((i_dividend == WORD_MIN) && (i_divisor == WORD_M1))
      begin
         o_quotient  = WORD_MIN;
         o_remainder = WORD_ZERO;
      end
      else
      begin
         o_quotient  = (i_dividend[15] ^ i_divisor[15]) ? 16'(~q_mag + 16'h0001) : q_mag;
         o_remainder = i_dividend[15] ? 16'(~r_mag + 16'h0001) : r_mag;
      end
   end
endmodule : smd_divider

// ===== bench/smd_regfile_model.sv
// partner model: register file words c and c+1 that take the unit's writes
`timescale 1ns/1ps
module smd_regfile_model
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   // writes from the unit
   input  wire logic        i_write_lo,
   input  wire logic        i_write_hi,
   input  wire logic [15:0] i_dest_lo,
   input  wire logic [15:0] i_dest_hi,
   // stored words
   output logic      [15:0] o_word_c,
   output logic      [15:0] o_word_c1
);
   // a word moves only under its own strobe, so a refused op shows as held data
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_word_c  <= 16'h0000;
         o_word_c1 <= 16'h0000;
      end
      else
      begin
         if (i_write_lo)
            o_word_c <= i_dest_lo;
         if (i_write_hi)
            o_word_c1 <= i_dest_hi;
      end
   end
endmodule : smd_regfile_model

// ===== bench/test_signed_mul_div_dword_addsub_unit.sv
// testbench: directed scenarios for the arithmetic unit
`timescale 1ns/1ps
module test_signed_mul_div_dword_addsub_unit;
   import smd_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        i_enable = 1'b0;
   smd_op_type  i_op = SMD_OP_MUL;
   logic [31:0] a = 32'h0;
   logic [31:0] b = 32'h0;
   logic        i_dest_index = 1'b0;
   logic        i_error_clear = 1'b0;
   logic [15:0] o_dest_lo;
   logic [15:0] o_dest_hi;
   logic        o_write_lo;
   logic        o_write_hi;
   logic        o_result_valid;
   logic        o_instruction_error_flag;
   logic [15:0] m_c;
   logic [15:0] m_c1;
   int          miscompares = 0;
   int          total_checks = 0;

   always #5 i_clk = ~i_clk;

   smd_unit dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_enable(i_enable), .i_op(i_op),
      .i_a_lo(a[15:0]), .i_a_hi(a[31:16]), .i_b_lo(b[15:0]), .i_b_hi(b[31:16]),
      .i_dest_index(i_dest_index), .i_error_clear(i_error_clear), .o_dest_lo(o_dest_lo),
      .o_dest_hi(o_dest_hi), .o_write_lo(o_write_lo), .o_write_hi(o_write_hi),
      .o_result_valid(o_result_valid), .o_instruction_error_flag(o_instruction_error_flag));
   smd_regfile_model regs (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_write_lo(o_write_lo),
      .i_write_hi(o_write_hi), .i_dest_lo(o_dest_lo), .i_dest_hi(o_dest_hi),
      .o_word_c(m_c), .o_word_c1(m_c1));

   task chk(input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk

   // flags are {write_lo, write_hi, valid, error}; data is read back from the model
   task go(input smd_op_type op, input logic [31:0] av, input logic [31:0] bv,
           input logic idx, input logic [3:0] f, input logic [31:0] d);
      i_op = op;
      a = av;
      b = bv;
      i_dest_index = idx;
      i_enable = 1'b1;
      @(posedge i_clk);
      #1;
      i_enable = 1'b0;
      chk({28'h0, f}, {28'h0, o_write_lo, o_write_hi, o_result_valid, o_instruction_error_flag});
      @(posedge i_clk);
      #1;
      chk(d, {m_c1, m_c});
   endtask : go

   task t_idle;
      i_op = SMD_OP_MUL;
      a = 32'h5;
      b = 32'h5;
      @(posedge i_clk);
      #1;
      chk(32'h0, {o_write_lo, o_write_hi, o_result_valid, o_instruction_error_flag});
      chk(32'h0, {m_c1, m_c});
   endtask : t_idle

   task t_mul;
      go(SMD_OP_MUL, 32'h5DC, 32'h14, 1'b0, 4'hE, 32'h0000_7530);
      go(SMD_OP_MUL, 32'hFFFE, 32'h3, 1'b0, 4'hE, 32'hFFFF_FFFA);
      go(SMD_OP_MUL, 32'h8000, 32'h8000, 1'b0, 4'hE, 32'h4000_0000);
   endtask : t_mul

   task t_div;
      go(SMD_OP_DIV, 32'hB4E, 32'h145, 1'b0, 4'hE, 32'h0126_0008);
      go(SMD_OP_DIV, 32'hFFF9, 32'h2, 1'b0, 4'hE, 32'hFFFF_FFFD);
      go(SMD_OP_DIV, 32'hB4E, 32'h145, 1'b1, 4'hA, 32'hFFFF_0008);
      go(SMD_OP_DIV, 32'h7, 32'hFFFE, 1'b0, 4'hE, 32'h0001_FFFD);
      go(SMD_OP_DIV, 32'h8000, 32'hFFFF, 1'b0, 4'hE, 32'h0000_8000);
   endtask : t_div

   task t_div_zero;
      go(SMD_OP_DIV, 32'h64, 32'h0, 1'b0, 4'h1, 32'h0000_8000);
      repeat (3) @(posedge i_clk);
      #1;
      chk(32'h1, {31'h0, o_instruction_error_flag});
      go(SMD_OP_MUL, 32'h2, 32'h3, 1'b0, 4'hF, 32'h0000_0006);
      // apart from reset, the program's explicit clear is the only way the flag drops
      i_error_clear = 1'b1;
      @(posedge i_clk);
      #1;
      i_error_clear = 1'b0;
      @(posedge i_clk);
      #1;
      chk(32'h0, {31'h0, o_instruction_error_flag});
      // a set in the same cycle as a clear wins; the clear acts one edge later
      i_error_clear = 1'b1;
      go(SMD_OP_DIV, 32'h64, 32'h0, 1'b0, 4'h1, 32'h0000_0006);
      i_error_clear = 1'b0;
      chk(32'h0, {31'h0, o_instruction_error_flag});
   endtask : t_div_zero

   task t_dadd;
      go(SMD_OP_DADD, 32'h493E0, 32'h186A0, 1'b0, 4'hC, 32'h0006_1A80);
      go(SMD_OP_DADD, 32'h7FFF_FFFE, 32'h1, 1'b0, 4'hC, 32'h7FFF_FFFF);
      go(SMD_OP_DADD, 32'h7FFF_FFFF, 32'h1, 1'b0, 4'hE, 32'h7FFF_FFFF);
      go(SMD_OP_DADD, 32'h8000_0000, 32'hFFFF_FFFF, 1'b0, 4'hE, 32'h8000_0000);
   endtask : t_dadd

   task t_dsub;
      go(SMD_OP_DSUB, 32'h181BE0, 32'h13880, 1'b0, 4'hC, 32'h0016_E360);
      go(SMD_OP_DSUB, 32'h8000_0000, 32'h1, 1'b0, 4'hE, 32'h8000_0000);
      go(SMD_OP_DSUB, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 1'b0, 4'hE, 32'h7FFF_FFFF);
      // most negative subtrahend from a negative minuend stays in range
      go(SMD_OP_DSUB, 32'hFFFF_FFFF, 32'h8000_0000, 1'b0, 4'hC, 32'h7FFF_FFFF);
   endtask : t_dsub

   task t_sub;
      go(SMD_OP_SUB, 32'h3A98, 32'h9C4, 1'b0, 4'h8, 32'h7FFF_30D4);
      go(SMD_OP_SUB, 32'h86E8, 32'h9C4, 1'b0, 4'hA, 32'h7FFF_8000);
      go(SMD_OP_SUB, 32'h7FFF, 32'hFFFF, 1'b0, 4'hA, 32'h7FFF_7FFF);
   endtask : t_sub

   task conclude;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (6) @(posedge i_clk);
      #1;
      i_arst_n = 1'b1;
      t_idle();
      t_mul();
      t_div();
      t_div_zero();
      t_dadd();
      t_dsub();
      t_sub();
      conclude();
   end
endmodule : test_signed_mul_div_dword_addsub_unit
